// file: rtl/spe_defs.svh
// constants for the serial programming entry link
`ifndef SPE_DEFS_SVH
`define SPE_DEFS_SVH
`define SPE_KEY_BITS 32
// key value is arbitrary, not tied to any maker
`define SPE_KEY_VALUE 32'h5a3c96e1
`define SPE_CLK_DIV 8
`define SPE_SESSION_BIT 0
`endif

// file: rtl/spe_device.sv
// device end: programming entry detect, key shift and session tracking
// Summary of operation
// - clock, data low then high voltage: enter
// - low-voltage entry only when enable bit set
// - clear low, 32 key bits, then enter
// - low-voltage session lasts while clear low
// - enable bit forces master clear reset on
// - enable bit cleared only in high-voltage session
// - data pin two-way, clock pin input only
// - session allows memory, id, config programming
`timescale 1ns/10ps
`include "spe_defs.svh"
module spe_device #(
    parameter int KEY_BITS = `SPE_KEY_BITS,
    parameter logic [31:0] KEY_VALUE = `SPE_KEY_VALUE
) (
    input wire logic clk_sys,
    input wire logic rstn,
    spe_link_if.device link,
    input wire logic low_voltage_prog_enable,
    input wire logic clear_reset_cfg,
    input wire logic reply_bit,
    input wire logic reply_oe,
    input wire logic enable_clear_req,
    output logic prog_mode,
    output spe_pkg::spe_entry_t entry_kind,
    output logic master_clear_reset_en,
    output logic master_clear,
    output logic enable_clear_ok,
    output logic enable_clear_pulse,
    output logic rx_bit,
    output logic rx_valid,
    output logic write_allowed
);
    initial begin
        if (KEY_BITS != 32) $error("key length must be 32");
    end
    logic [1:0] clk_s, dat_s, clr_s, hv_s;
    logic clk_d;
    logic [31:0] shift;
    logic [5:0] count;
    spe_pkg::spe_state_t state;
    logic clk_rise;
    // two flops on every pin input, nothing reads stage one
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clk_s <= 2'h0;
            dat_s <= 2'h0;
            clr_s <= 2'h3;
            hv_s <= 2'h0;
            clk_d <= 1'b0;
        end else begin
            clk_s <= {clk_s[0], link.prog_clock_pin};
            dat_s <= {dat_s[0], link.prog_data_pin};
            clr_s <= {clr_s[0], link.clear_or_hv_pin};
            hv_s <= {hv_s[0], link.high_programming_voltage};
            clk_d <= clk_s[1];
        end
    end
    assign clk_rise = clk_s[1] & ~clk_d;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= spe_pkg::SPE_IDLE;
            shift <= 32'h0;
            count <= 6'h0;
        end else begin
            unique case (state)
                spe_pkg::SPE_IDLE: begin
                    count <= 6'h0;
                    if (hv_s[1] && !clk_s[1] && !dat_s[1]) begin
                        state <= spe_pkg::SPE_PROG_HV;
                    end else if (!clr_s[1] && low_voltage_prog_enable) begin
                        state <= spe_pkg::SPE_KEY;
                    end
                end
                spe_pkg::SPE_KEY: begin
                    if (clr_s[1]) begin
                        state <= spe_pkg::SPE_IDLE;
                    end else if (clk_rise) begin
                        shift <= {shift[30:0], dat_s[1]};
                        count <= count + 6'h1;
                        if (count == 6'(KEY_BITS - 1)) begin
                            if ({shift[30:0], dat_s[1]} == KEY_VALUE) begin
                                state <= spe_pkg::SPE_PROG_LV;
                            end else begin
                                state <= spe_pkg::SPE_REJECT;
                            end
                        end
                    end
                end
                spe_pkg::SPE_PROG_LV: begin
                    if (clr_s[1]) begin
                        state <= spe_pkg::SPE_IDLE;
                    end
                end
                spe_pkg::SPE_PROG_HV: begin
                    if (!hv_s[1]) begin
                        state <= spe_pkg::SPE_IDLE;
                    end
                end
                spe_pkg::SPE_REJECT: begin
                    if (clr_s[1]) begin
                        state <= spe_pkg::SPE_IDLE;
                    end
                end
                default: state <= spe_pkg::SPE_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_bit <= 1'b0;
            rx_valid <= 1'b0;
            enable_clear_pulse <= 1'b0;
        end else begin
            rx_bit <= dat_s[1];
            // serial traffic only inside a session
            rx_valid <= prog_mode & clk_rise & ~reply_oe;
            enable_clear_pulse <= enable_clear_req & enable_clear_ok;
        end
    end
    assign prog_mode = (state == spe_pkg::SPE_PROG_LV) || (state == spe_pkg::SPE_PROG_HV);
    assign entry_kind = (state == spe_pkg::SPE_PROG_HV) ? spe_pkg::SPE_ENTRY_HV :
        (state == spe_pkg::SPE_PROG_LV) ? spe_pkg::SPE_ENTRY_LV : spe_pkg::SPE_ENTRY_NONE;
    assign write_allowed = prog_mode;
    assign enable_clear_ok = (state == spe_pkg::SPE_PROG_HV);
    // enable bit set overrides the configuration choice
    assign master_clear_reset_en = low_voltage_prog_enable | clear_reset_cfg;
    assign master_clear = ~clr_s[1] & master_clear_reset_en & ~prog_mode;
    // device drives data only when asked during a session
    assign link.data_from_dev = reply_bit;
    assign link.data_dev_oe = prog_mode & reply_oe;
endmodule // spe_device

// file: rtl/spe_link_if.sv
// pin level interface between programmer and target
`timescale 1ns/10ps
interface spe_link_if;
    logic prog_clock_pin;
    logic clear_or_hv_pin;
    logic high_programming_voltage;
    logic data_from_prog;
    logic data_prog_oe;
    logic data_from_dev;
    logic data_dev_oe;
    logic prog_data_pin;
    assign prog_data_pin = data_prog_oe ? data_from_prog : (data_dev_oe ? data_from_dev : 1'b0);
    modport device (
        input prog_clock_pin,
        input clear_or_hv_pin,
        input high_programming_voltage,
        input prog_data_pin,
        output data_from_dev,
        output data_dev_oe
    );
    modport programmer (
        output prog_clock_pin,
        output clear_or_hv_pin,
        output high_programming_voltage,
        input prog_data_pin,
        output data_from_prog,
        output data_prog_oe
    );
endinterface

// file: rtl/spe_pkg.sv
// types used by the device end of the programming entry link and its checker
package spe_pkg;
    typedef enum logic [2:0] {
        SPE_IDLE = 3'b000,
        SPE_KEY = 3'b001,
        SPE_PROG_LV = 3'b010,
        SPE_PROG_HV = 3'b011,
        SPE_REJECT = 3'b100
    } spe_state_t;
    typedef enum logic [1:0] {
        SPE_ENTRY_NONE = 2'b00,
        SPE_ENTRY_HV = 2'b01,
        SPE_ENTRY_LV = 2'b10
    } spe_entry_t;
endpackage

// file: rtl/spe_programmer.sv
// programmer end: drives clock, clear and data for either entry method
`timescale 1ns/10ps
`include "spe_defs.svh"
module spe_programmer #(
    parameter int CLK_DIV = `SPE_CLK_DIV,
    parameter logic [31:0] KEY_VALUE = `SPE_KEY_VALUE
) (
    input wire logic clk_sys,
    input wire logic rstn,
    spe_link_if.programmer link,
    input wire logic start_hv,
    input wire logic start_lv,
    input wire logic end_session,
    output logic busy,
    output logic in_session
);
    initial begin
        if (CLK_DIV < 2) $error("clock divider must be at least 2");
    end
    typedef enum logic [1:0] {
        SPP_IDLE = 2'b00,
        SPP_SHIFT = 2'b01,
        SPP_HOLD = 2'b10
    } spp_state_t;
    spp_state_t state;
    logic [31:0] shift;
    logic [5:0] count;
    logic [7:0] div;
    logic sclk, hv, clr, lvmode;
    logic half;
    assign half = (div == 8'(CLK_DIV / 2 - 1));
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= SPP_IDLE;
            shift <= 32'h0;
            count <= 6'h0;
            div <= 8'h0;
            sclk <= 1'b0;
            hv <= 1'b0;
            clr <= 1'b1;
            lvmode <= 1'b0;
        end else begin
            unique case (state)
                SPP_IDLE: begin
                    sclk <= 1'b0;
                    div <= 8'h0;
                    if (start_hv) begin
                        // clock and data already low here
                        hv <= 1'b1;
                        lvmode <= 1'b0;
                        state <= SPP_HOLD;
                    end else if (start_lv) begin
                        clr <= 1'b0;
                        shift <= KEY_VALUE;
                        count <= 6'h0;
                        lvmode <= 1'b1;
                        state <= SPP_SHIFT;
                    end
                end
                SPP_SHIFT: begin
                    div <= half ? 8'h0 : div + 8'h1;
                    if (half) begin
                        sclk <= ~sclk;
                        if (sclk) begin
                            shift <= {shift[30:0], 1'b0};
                            count <= count + 6'h1;
                            if (count == 6'd31) begin
                                state <= SPP_HOLD;
                            end
                        end
                    end
                end
                SPP_HOLD: begin
                    sclk <= 1'b0;
                    if (end_session) begin
                        hv <= 1'b0;
                        clr <= 1'b1;
                        state <= SPP_IDLE;
                    end
                end
                default: state <= SPP_IDLE;
            endcase
        end
    end
    assign busy = (state != SPP_IDLE);
    assign in_session = (state == SPP_HOLD) & (hv | lvmode);
    assign link.prog_clock_pin = sclk;
    assign link.clear_or_hv_pin = clr | hv;
    assign link.high_programming_voltage = hv;
    assign link.data_from_prog = (state == SPP_SHIFT) ? shift[31] : 1'b0;
    assign link.data_prog_oe = (state != SPP_HOLD);
endmodule // spe_programmer

// file: test/spe_link_chk.sv
// assertions on the programming entry link
`timescale 1ns/10ps
module spe_link_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic prog_clock_pin,
    input wire logic clear_or_hv_pin,
    input wire logic high_programming_voltage,
    input wire logic prog_data_pin,
    input wire logic data_dev_oe,
    input wire logic low_voltage_prog_enable,
    input wire logic prog_mode,
    input wire spe_pkg::spe_entry_t entry_kind,
    input wire logic master_clear_reset_en,
    input wire logic enable_clear_ok
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_hv_entry_seen: assert property ($rose(high_programming_voltage) && !prog_clock_pin && !prog_data_pin
        |-> ##[1:5] prog_mode) else $error("hv entry missed");
    a_hv_exit: assert property ($fell(high_programming_voltage) && entry_kind == spe_pkg::SPE_ENTRY_HV
        |-> ##[1:5] !prog_mode) else $error("hv session kept");
    a_lv_needs_enable: assert property ($rose(prog_mode) && entry_kind == spe_pkg::SPE_ENTRY_LV
        |-> low_voltage_prog_enable && !clear_or_hv_pin) else $error("lv entry not allowed");
    a_lv_exit: assert property ($rose(clear_or_hv_pin) && entry_kind == spe_pkg::SPE_ENTRY_LV
        |-> ##[1:5] !prog_mode) else $error("lv session kept");
    a_clear_forced: assert property (low_voltage_prog_enable |-> master_clear_reset_en)
        else $error("clear reset not forced");
    a_enable_clear_hv: assert property (enable_clear_ok |-> prog_mode && entry_kind == spe_pkg::SPE_ENTRY_HV)
        else $error("enable clear outside hv");
    a_dev_drive: assert property (data_dev_oe |-> prog_mode)
        else $error("device drives data outside session");
    a_mode_kind: assert property (prog_mode |-> entry_kind != spe_pkg::SPE_ENTRY_NONE)
        else $error("session without entry kind");
endmodule // spe_link_chk

// file: test/tb_serial_programming_entry.sv
// self-checking bench for the programming entry link
`timescale 1ns/10ps
`include "spe_defs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_serial_programming_entry;
    logic clk_sys = 0, rstn = 0, lv_en = 1, cfg = 0, rbit = 0, roe = 0, clr_req = 0;
    logic start_hv = 0, start_lv = 0, end_s = 0, busy, in_s, pm, pm2, mcr, lok, lcp, wa;
    spe_pkg::spe_entry_t ek, ek2;
    logic [31:0] key;
    int num_errors = 0, check_count = 0;
    spe_link_if lk ();
    spe_link_if lk2 ();
    always #2.5 clk_sys = ~clk_sys;
    spe_programmer spe_programmer_inst (.clk_sys, .rstn, .link(lk.programmer), .start_hv, .start_lv,
        .end_session(end_s), .busy, .in_session(in_s));
    spe_device spe_device_inst (.clk_sys, .rstn, .link(lk.device), .low_voltage_prog_enable(lv_en),
        .clear_reset_cfg(cfg), .reply_bit(rbit), .reply_oe(roe), .enable_clear_req(clr_req), .prog_mode(pm),
        .entry_kind(ek), .master_clear_reset_en(mcr), .master_clear(), .enable_clear_ok(lok),
        .enable_clear_pulse(lcp), .rx_bit(), .rx_valid(), .write_allowed(wa));
    // second target, fed by the bench to break the key on purpose
    spe_device spe_device_inst2 (.clk_sys, .rstn, .link(lk2.device), .low_voltage_prog_enable(lv_en),
        .clear_reset_cfg(cfg), .reply_bit(rbit), .reply_oe(1'b0), .enable_clear_req(clr_req), .prog_mode(pm2),
        .entry_kind(ek2), .master_clear_reset_en(), .master_clear(), .enable_clear_ok(),
        .enable_clear_pulse(), .rx_bit(), .rx_valid(), .write_allowed());
    spe_link_chk spe_link_chk_inst (.clk_sys, .rstn, .prog_clock_pin(lk.prog_clock_pin),
        .clear_or_hv_pin(lk.clear_or_hv_pin), .high_programming_voltage(lk.high_programming_voltage),
        .prog_data_pin(lk.prog_data_pin), .data_dev_oe(lk.data_dev_oe), .low_voltage_prog_enable(lv_en),
        .prog_mode(pm), .entry_kind(ek), .master_clear_reset_en(mcr), .enable_clear_ok(lok));
    function automatic spe_pkg::spe_entry_t model(int hv, int en, logic [31:0] k, int fresh);
        if (hv) return spe_pkg::SPE_ENTRY_HV;
        return (en && fresh && k === `SPE_KEY_VALUE) ? spe_pkg::SPE_ENTRY_LV : spe_pkg::SPE_ENTRY_NONE;
    endfunction
    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask
    task automatic wait_pm(logic w);
        for (int i = 0; i < 2000 && pm !== w; i++) cyc(1);
    endtask
    // bench clock only runs inside a frame, 80 ns period
    task automatic shift2(logic [31:0] k);
        for (int i = 31; i >= 0; i--) begin
            lk2.data_from_prog = k[i];
            #40 lk2.prog_clock_pin = 1;
            #40 lk2.prog_clock_pin = 0;
        end
        cyc(8);
    endtask
    task automatic complete_run;
        if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {lk2.prog_clock_pin, lk2.high_programming_voltage, lk2.data_from_prog} = 3'h0;
        lk2.clear_or_hv_pin = 1;
        lk2.data_prog_oe = 1;
        void'($urandom(32'h3d7f5e26));
        cyc(3);
        rstn = 1;
        cyc(3);
        pulse(start_hv);
        wait_pm(1);
        `CHK("hv kind", model(1, 1, 0, 0), ek)
        `CHK("clear ok", 1'b1, lok)
        pulse(clr_req);
        `CHK("clear pulse hv", 1'b1, lcp)
        `CHK("write allowed", 1'b1, wa)
        pulse(end_s);
        wait_pm(0);
        `CHK("hv end", 1'b0, pm)
        pulse(start_lv);
        wait_pm(1);
        `CHK("lv kind", model(0, 1, `SPE_KEY_VALUE, 1), ek)
        `CHK("clear forced", 1'b1, mcr)
        `CHK("no clear in lv", 1'b0, lok)
        pulse(clr_req);
        `CHK("clear pulse lv", 1'b0, lcp)
        rbit = 1'($urandom);
        roe = 1;
        cyc(3);
        `CHK("reply", rbit, lk.prog_data_pin)
        roe = 0;
        pulse(end_s);
        wait_pm(0);
        `CHK("lv end", 1'b0, pm)
        lv_en = 0;
        pulse(start_lv);
        cyc(600);
        `CHK("lv refused", model(0, 0, `SPE_KEY_VALUE, 1), ek)
        pulse(end_s);
        cyc(10);
        lv_en = 1;
        key = $urandom;
        if (key === `SPE_KEY_VALUE) key = ~key;
        lk2.clear_or_hv_pin = 0;
        cyc(4);
        shift2(key);
        `CHK("bad key", model(0, 1, key, 1), ek2)
        shift2(`SPE_KEY_VALUE);
        `CHK("no retry", model(0, 1, `SPE_KEY_VALUE, 0), ek2)
        lk2.clear_or_hv_pin = 1;
        cyc(8);
        lk2.clear_or_hv_pin = 0;
        cyc(4);
        shift2(`SPE_KEY_VALUE);
        `CHK("retry", model(0, 1, `SPE_KEY_VALUE, 1), ek2)
        lk2.clear_or_hv_pin = 1;
        cyc(8);
        `CHK("released", model(0, 0, 0, 0), ek2)
        complete_run;
    end
    initial begin
        #100000;
        num_errors++;
        complete_run;
    end
endmodule // tb_serial_programming_entry
